// ---- hdl/fspm_ctrl.sv ----
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "fspm_consts.svh"
// Self-programming mode controller
// Software enters the mode through the control word, then parks the CPU
// In a halt that releases on its own after a fixed count of clocks
// Write and erase commands run only from the ready state
// While a command runs the CPU is stalled and RAM is gated off
// Interrupt requests seen in the mode are gathered, not passed on
// They are handed to the CPU one clock after the mode ends
// Pins keep the value they had at entry for the whole mode
// Register map, all words 32 bits, narrow fields in the low bits:
//   Control: mode enter or leave, halt request
//   Status: mode, halt, busy, pending interrupt
//   Command: write one byte or erase one block
//   Address, write byte, array read byte
//   Event status, event clear, event enable
// Events: command finished, halt released
// Limitations:
//   Halt request is a stand-in for the CPU halt instruction
//   Array is a plain register file; no timing of real cells
//   No protect or security checks in this block
//   Firmware duties are not policed by the hardware:
//     mask setup, clock floor, wait after release, bit access,
//     clearing of the upper pointer bits
// Trade-off: the release delay is a count of clocks, so a slower
// System clock lengthens the halt; the parameter must be sized
// For the real clock rate to keep the time bound
module fspm_ctrl #(
  parameter int ADDR_W = 8,
  parameter int DEPTH = 256,
  parameter int BLOCK_W = 4,
  parameter int IRQ_W = 8,
  parameter int REL_CYC = `FSPM_REL_CYC
) (
  input wire logic CLK_SYS, // System clock 10 MHz
  input wire logic NRST, // Synchronous reset, active low
  input wire fspm_pkg::fspm_bus_t BUS, // Register bus request
  input wire logic [IRQ_W-1:0] IRQ_REQ, // Raw peripheral requests
  input wire logic [IRQ_W-1:0] PIN_OUT_IN, // Normal pin output values
  output logic [31:0] RDATA, // Read data, cycle after read
  output logic [IRQ_W-1:0] IRQ_ACK_REQ, // Requests passed to the CPU
  output logic CPU_STALL, // Holds CPU in wait
  output logic RAM_EN, // On-chip RAM access enable
  output logic [IRQ_W-1:0] PIN_OUT, // Pin drive values
  output logic IRQ // Level interrupt to CPU
);
  fspm_pkg::fspm_state_t state_r, state_nxt; // Sequencer state
  logic [$clog2(REL_CYC+1)-1:0] rel_cnt_r; // Halt release counter
  logic [7:0] mem_r [DEPTH]; // Flash array model
  logic [ADDR_W-1:0] addr_r; // Target address
  logic [7:0] wdata_r; // Write byte
  logic [7:0] rdata_byte_r; // Array read byte
  logic [7:0] cmd_r; // Pending command
  logic [BLOCK_W-1:0] erase_cnt_r; // Erase walk index
  logic [IRQ_W-1:0] pend_r; // Deferred interrupt requests
  logic [IRQ_W-1:0] pin_hold_r; // Pin state frozen at entry
  logic [1:0] irq_stat_r; // Sticky event bits
  logic [1:0] irq_en_r; // Event enables
  logic [1:0] ev; // Events this cycle
  logic mode_on; // Self-programming active
  logic wr_ctrl, wr_cmd, rel_done, erase_last;

  assign mode_on = (state_r != fspm_pkg::FSPM_IDLE);
  assign wr_ctrl = BUS.wr && (BUS.addr == `FSPM_OFF_CTRL);
  assign wr_cmd = BUS.wr && (BUS.addr == `FSPM_OFF_CMD);
  assign rel_done = (state_r == fspm_pkg::FSPM_HALT) && (rel_cnt_r == 1);
  assign erase_last = (erase_cnt_r == {BLOCK_W{1'b1}});

  // Next state
  // Idle goes to ready on a mode write
  // Ready accepts halt, leave, write and erase in that priority
  // Halt stays until the release counter runs out
  // Write takes one clock, erase one clock per byte of the block
  // Commands written outside ready are stored but never run
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fspm_pkg::FSPM_IDLE: begin
        if (wr_ctrl && BUS.wdata[`FSPM_CTRL_MODE_BIT]) begin
          state_nxt = fspm_pkg::FSPM_READY;
        end
      end
      fspm_pkg::FSPM_READY: begin
        // Halt request after entry starts the auto release
        if (wr_ctrl && BUS.wdata[`FSPM_CTRL_HALT_BIT]) begin
          state_nxt = fspm_pkg::FSPM_HALT;
        end else if (wr_ctrl && !BUS.wdata[`FSPM_CTRL_MODE_BIT]) begin
          state_nxt = fspm_pkg::FSPM_IDLE;
        end else if (wr_cmd && BUS.wdata[7:0] == `FSPM_CMD_WRITE) begin
          state_nxt = fspm_pkg::FSPM_WRITE;
        end else if (wr_cmd && BUS.wdata[7:0] == `FSPM_CMD_ERASE) begin
          state_nxt = fspm_pkg::FSPM_ERASE;
        end
      end
      fspm_pkg::FSPM_HALT: begin
        if (rel_done) begin
          state_nxt = fspm_pkg::FSPM_READY;
        end
      end
      fspm_pkg::FSPM_WRITE: state_nxt = fspm_pkg::FSPM_READY;
      fspm_pkg::FSPM_ERASE: begin
        if (erase_last) begin
          state_nxt = fspm_pkg::FSPM_READY;
        end
      end
      default: state_nxt = fspm_pkg::FSPM_IDLE;
    endcase
  end

  // State register; reset aborts any operation mid-way
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      state_r <= fspm_pkg::FSPM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Halt release countdown, exactly 10 us plus 2 clocks
  // Loaded in every state but halt, so each halt starts full
  // Halt lasts exactly REL_CYC clocks: the release fires at a count of one
  // And the next state leaves halt at that edge
  // Stops at zero so a stuck halt cannot wrap the counter
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      rel_cnt_r <= '0;
    end else if (state_r != fspm_pkg::FSPM_HALT) begin
      rel_cnt_r <= ($clog2(REL_CYC+1))'(REL_CYC);
    end else if (rel_cnt_r != 0) begin
      rel_cnt_r <= rel_cnt_r - 1'b1;
    end
  end

  // Address, data and command capture
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      addr_r <= '0;
      wdata_r <= 8'h00;
      cmd_r <= `FSPM_CMD_NONE;
    end else begin
      if (BUS.wr && BUS.addr == `FSPM_OFF_ADDR) begin
        addr_r <= BUS.wdata[ADDR_W-1:0];
      end
      if (BUS.wr && BUS.addr == `FSPM_OFF_WDATA) begin
        wdata_r <= BUS.wdata[7:0];
      end
      if (wr_cmd) begin
        cmd_r <= BUS.wdata[7:0];
      end
    end
  end

  // Erase walk over one block
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      erase_cnt_r <= '0;
    end else if (state_r == fspm_pkg::FSPM_ERASE) begin
      erase_cnt_r <= erase_cnt_r + 1'b1;
    end else begin
      erase_cnt_r <= '0;
    end
  end

  // Flash array; no reset so contents survive, but not an interrupted op
  // Erase walks the block low to high, one byte a clock
  // A reset in mid-walk leaves the upper bytes untouched
  // Read byte follows the address with one clock of latency
  // Write and erase never overlap: only one state can be active
  always_ff @(posedge CLK_SYS) begin
    if (state_r == fspm_pkg::FSPM_WRITE) begin
      mem_r[addr_r] <= wdata_r;
    end else if (state_r == fspm_pkg::FSPM_ERASE) begin
      mem_r[{addr_r[ADDR_W-1:BLOCK_W], erase_cnt_r}] <= `FSPM_BLANK;
    end
    rdata_byte_r <= mem_r[addr_r];
  end

  // Deferred interrupt capture during the mode
  // Requests are or-ed into a pending word and held
  // Nothing reaches the CPU after the first clock of the mode
  // On exit the pending word and live requests go out together
  // Pending is dropped one clock after exit, once handed over
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      pend_r <= '0;
      IRQ_ACK_REQ <= '0;
    end else if (mode_on) begin
      pend_r <= pend_r | IRQ_REQ;
      IRQ_ACK_REQ <= '0;
    end else begin
      pend_r <= '0;
      IRQ_ACK_REQ <= pend_r | IRQ_REQ;
    end
  end

  // CPU stall and RAM gating; no instruction runs during a command
  // Taken from the next state so both change on the entry edge
  // RAM stays enabled in halt: only commands keep it idle
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      CPU_STALL <= 1'b0;
      RAM_EN <= 1'b1;
    end else begin
      CPU_STALL <= (state_nxt == fspm_pkg::FSPM_HALT) ||
                   (state_nxt == fspm_pkg::FSPM_WRITE) ||
                   (state_nxt == fspm_pkg::FSPM_ERASE);
      RAM_EN <= (state_nxt != fspm_pkg::FSPM_WRITE) &&
                (state_nxt != fspm_pkg::FSPM_ERASE);
    end
  end

  // Pins frozen as in HALT while the mode is active
  // Hold register tracks the pins outside the mode
  // So the frozen value is the one seen at the entry edge
  // Pins drive low during reset
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      pin_hold_r <= '0;
      PIN_OUT <= '0;
    end else if (!mode_on) begin
      pin_hold_r <= PIN_OUT_IN;
      PIN_OUT <= PIN_OUT_IN;
    end else begin
      PIN_OUT <= pin_hold_r;
    end
  end

  // Events: command done, halt released
  assign ev[`FSPM_IRQ_DONE_BIT] = (state_r == fspm_pkg::FSPM_WRITE) ||
                                  ((state_r == fspm_pkg::FSPM_ERASE) && erase_last);
  assign ev[`FSPM_IRQ_REL_BIT] = rel_done;

  // Sticky status; a same-cycle event beats the clear
  // Clear is write-one; zero bits leave status alone
  // Interrupt line lags the status by one clock
  // Enables do not gate the status, only the line
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      irq_stat_r <= 2'h0;
      irq_en_r <= 2'h0;
      IRQ <= 1'b0;
    end else begin
      if (BUS.wr && BUS.addr == `FSPM_OFF_IRQ_CLR) begin
        irq_stat_r <= (irq_stat_r & ~BUS.wdata[1:0]) | ev;
      end else begin
        irq_stat_r <= irq_stat_r | ev;
      end
      if (BUS.wr && BUS.addr == `FSPM_OFF_IRQ_EN) begin
        irq_en_r <= BUS.wdata[1:0];
      end
      IRQ <= |(irq_stat_r & irq_en_r);
    end
  end

  // Read data, valid only in the cycle after the strobe
  // Returns zero at all other times so a stale word never lingers
  // Clear register and unmapped offsets read as zero
  // Status busy covers both write and erase
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      RDATA <= 32'h0000_0000;
    end else if (BUS.rd) begin
      case (BUS.addr)
        `FSPM_OFF_CTRL: RDATA <= {30'h0, state_r == fspm_pkg::FSPM_HALT, mode_on};
        `FSPM_OFF_STAT: RDATA <= {28'h0, |pend_r,
                                  state_r == fspm_pkg::FSPM_WRITE ||
                                  state_r == fspm_pkg::FSPM_ERASE,
                                  state_r == fspm_pkg::FSPM_HALT, mode_on};
        `FSPM_OFF_CMD: RDATA <= {24'h0, cmd_r};
        `FSPM_OFF_ADDR: RDATA <= 32'(addr_r);
        `FSPM_OFF_WDATA: RDATA <= {24'h0, wdata_r};
        `FSPM_OFF_RDATA: RDATA <= {24'h0, rdata_byte_r};
        `FSPM_OFF_IRQ_STAT: RDATA <= {30'h0, irq_stat_r};
        `FSPM_OFF_IRQ_EN: RDATA <= {30'h0, irq_en_r};
        default: RDATA <= 32'h0000_0000;
      endcase
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end
endmodule

// ---- include/fspm_consts.svh ----
`ifndef FSPM_CONSTS_SVH
`define FSPM_CONSTS_SVH
// Register offsets
`define FSPM_OFF_CTRL 8'h00
`define FSPM_OFF_STAT 8'h04
`define FSPM_OFF_CMD 8'h08
`define FSPM_OFF_ADDR 8'h0C
`define FSPM_OFF_WDATA 8'h10
`define FSPM_OFF_RDATA 8'h14
`define FSPM_OFF_IRQ_STAT 8'h18
`define FSPM_OFF_IRQ_CLR 8'h1C
`define FSPM_OFF_IRQ_EN 8'h20
// Control field positions
`define FSPM_CTRL_MODE_BIT 0
`define FSPM_CTRL_HALT_BIT 1
// Status field positions
`define FSPM_STAT_MODE_BIT 0
`define FSPM_STAT_HALT_BIT 1
`define FSPM_STAT_BUSY_BIT 2
`define FSPM_STAT_PEND_BIT 3
// Interrupt status bits
`define FSPM_IRQ_DONE_BIT 0
`define FSPM_IRQ_REL_BIT 1
// Commands
`define FSPM_CMD_NONE 8'h00
`define FSPM_CMD_WRITE 8'h01
`define FSPM_CMD_ERASE 8'h02
// Blank value
`define FSPM_BLANK 8'hFF
// Timing: halt release delay in ns plus fixed cycles
`define FSPM_CLK_NS 100
`define FSPM_REL_NS 10000
`define FSPM_REL_CYC ((`FSPM_REL_NS / `FSPM_CLK_NS) + 2)
`define FSPM_REL_RESET 1'b0
`endif

// ---- include/fspm_pkg.sv ----
package fspm_pkg;
  // Operating state of the sequencer
  typedef enum logic [2:0] {
    FSPM_IDLE,
    FSPM_HALT,
    FSPM_READY,
    FSPM_WRITE,
    FSPM_ERASE
  } fspm_state_t;
  // Register bus request bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } fspm_bus_t;
endpackage

// ---- tb/fspm_ctrl_sva.sv ----
`timescale 1ns/10ps
`include "fspm_consts.svh"
module fspm_ctrl_sva #(
  parameter int IRQ_W = 8,
  parameter int REL_CYC = 102
) (
  input wire logic CLK_SYS, // Clock
  input wire logic NRST, // Reset
  input wire fspm_pkg::fspm_bus_t BUS, // Bus
  input wire logic [IRQ_W-1:0] IRQ_REQ, // Requests
  input wire logic [IRQ_W-1:0] PIN_OUT_IN, // Pins in
  input wire logic [31:0] RDATA, // Read data
  input wire logic [IRQ_W-1:0] IRQ_ACK_REQ, // To CPU
  input wire logic CPU_STALL, // Stall
  input wire logic RAM_EN, // RAM enable
  input wire logic [IRQ_W-1:0] PIN_OUT, // Pins out
  input wire logic IRQ // Interrupt
);
  localparam int RMAX = REL_CYC + 2; // Release bound
  logic mode_r; // Mode mirror
  logic mode_q; // Mode delayed
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // Mode mirror; delayed copy hides the entry edge
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      mode_r <= 1'b0;
      mode_q <= 1'b0;
    end else begin
      if (BUS.wr && BUS.addr == `FSPM_OFF_CTRL) mode_r <= BUS.wdata[0];
      mode_q <= mode_r;
    end
  end
  a_ack_defer: assert property (mode_r && mode_q |-> IRQ_ACK_REQ == '0)
    else $error("ack during mode");
  a_ram_idle: assert property (!RAM_EN |-> CPU_STALL && mode_r)
    else $error("RAM off outside command");
  a_halt_release: assert property (BUS.wr && BUS.addr == `FSPM_OFF_CTRL && BUS.wdata[1]
    ##[1:2] $rose(CPU_STALL) |-> ##[1:RMAX] !CPU_STALL)
    else $error("halt not released");
  a_pin_hold: assert property (mode_r && mode_q |-> $stable(PIN_OUT))
    else $error("pins moved in mode");
  a_ack_outside: assert property (IRQ_ACK_REQ != '0 |-> !$past(mode_r))
    else $error("ack while mode on");
  a_pin_follow: assert property ($past(NRST) && !$past(mode_r) |-> PIN_OUT == $past(PIN_OUT_IN))
    else $error("pins not following");
endmodule
bind fspm_ctrl fspm_ctrl_sva #(.IRQ_W(IRQ_W), .REL_CYC(REL_CYC)) u_fspm_ctrl_sva (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .BUS(BUS), .IRQ_REQ(IRQ_REQ), .PIN_OUT_IN(PIN_OUT_IN),
  .RDATA(RDATA), .IRQ_ACK_REQ(IRQ_ACK_REQ), .CPU_STALL(CPU_STALL), .RAM_EN(RAM_EN),
  .PIN_OUT(PIN_OUT), .IRQ(IRQ));

// ---- tb/fspm_cpu_model.sv ----
`timescale 1ns/10ps
module fspm_cpu_model (
  input wire logic [7:0] raise, // Requests to raise
  output logic [7:0] irq_req // Peripheral requests
);
  // Masks left open so deferred servicing shows up
  assign irq_req = raise;
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`include "fspm_consts.svh"
module testbench;
  logic clk = 1'b0; // Clock, 10 MHz
  logic nrst = 1'b0; // Reset
  fspm_pkg::fspm_bus_t bus = '0; // Bus
  logic [7:0] raise = 8'h00; // Requests
  logic [7:0] pins = 8'hA5; // Pins in
  logic [31:0] rdata; // Read data
  logic [7:0] ack, irq_req, pin_out; // Outputs
  logic stall, ram_en, irq, seen; // Flags
  int fails = 0; // Mismatches
  int n_tests = 0; // Compares
  int n; // Stall count
  // Clock; 10 MHz keeps CPU clock above 1 MHz
  always #50 clk = ~clk;
  fspm_ctrl #(.REL_CYC(5)) u_fspm_ctrl (.CLK_SYS(clk), .NRST(nrst), .BUS(bus),
    .IRQ_REQ(irq_req), .PIN_OUT_IN(pins), .RDATA(rdata), .IRQ_ACK_REQ(ack),
    .CPU_STALL(stall), .RAM_EN(ram_en), .PIN_OUT(pin_out), .IRQ(irq));
  fspm_cpu_model u_fspm_cpu_model (.raise(raise), .irq_req(irq_req));
  // Count and report
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // One-cycle write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask
  // Read; data stands only in next cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 chk(rdata === e, "read data");
  endtask
  // Verdict
  task automatic tally_and_finish;
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  initial begin
    #500000;
    fails++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(`FSPM_OFF_STAT, 32'h0);
    wr(`FSPM_OFF_IRQ_EN, 32'h2);
    wr(`FSPM_OFF_CTRL, 32'h1);
    raise <= 8'h04;
    pins <= 8'h5A;
    repeat (4) @(posedge clk);
    #1 chk(ack === 8'h00, "ack in mode");
    chk(pin_out === 8'hA5, "pins frozen");
    raise <= 8'h00;
    wr(`FSPM_OFF_CTRL, 32'h3);
    n = 0;
    @(posedge clk) #1;
    while (stall === 1'b1 && n < 50) begin
      @(posedge clk) #1;
      n++;
    end
    chk(n > 0 && n <= 7, "halt release");
    repeat (80) @(posedge clk);
    rd(`FSPM_OFF_IRQ_STAT, 32'h2);
    chk(irq === 1'b1, "irq raised");
    wr(`FSPM_OFF_IRQ_CLR, 32'h2);
    rd(`FSPM_OFF_IRQ_STAT, 32'h0);
    chk(irq === 1'b0, "irq cleared");
    wr(`FSPM_OFF_ADDR, 32'h23);
    wr(`FSPM_OFF_WDATA, 32'h3C);
    wr(`FSPM_OFF_CMD, {24'h0, `FSPM_CMD_WRITE});
    #1 seen = !ram_en;
    repeat (4) @(posedge clk) #1 seen |= !ram_en;
    chk(seen, "RAM off in command");
    rd(`FSPM_OFF_RDATA, 32'h3C);
    rd(`FSPM_OFF_IRQ_STAT, 32'h1);
    chk(irq === 1'b0, "masked irq");
    wr(`FSPM_OFF_CMD, {24'h0, `FSPM_CMD_ERASE});
    repeat (20) @(posedge clk);
    rd(`FSPM_OFF_RDATA, {24'h0, `FSPM_BLANK});
    wr(`FSPM_OFF_ADDR, 32'h2F);
    rd(`FSPM_OFF_RDATA, {24'h0, `FSPM_BLANK});
    wr(`FSPM_OFF_CTRL, 32'h0);
    seen = 1'b0;
    repeat (3) @(posedge clk) #1 seen |= ack[2];
    chk(seen, "deferred ack");
    wr(`FSPM_OFF_CTRL, 32'h1);
    wr(`FSPM_OFF_CTRL, 32'h3);
    repeat (15) @(posedge clk);
    wr(`FSPM_OFF_CMD, {24'h0, `FSPM_CMD_ERASE});
    repeat (3) @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(stall === 1'b0 && ram_en === 1'b1 && pin_out === 8'h00, "reset");
    tally_and_finish;
  end
endmodule
